/* logic/scpc_top.sv */
// system clock generation, clock gating and power-mode control
//
// Notes on behaviour
// - after reset the pll is powered down and bypassed until enabled
// - feedback multiplier takes integer values one to thirty-two
// - post-divider offers divide by two, four, eight or sixteen
// - pll reports lock after a 100 microsecond settle count from enable
// - output pin selector routes rc, system osc, watchdog osc or main clock
// - power-up and deep power-down wake run from the 12 MHz rc oscillator
// - watchdog oscillator can clock the cpu, watchdog timer and output pin
// - watchdog oscillator frequency is programmable from 7.8 kHz to 1.7 MHz
// - three reduced-power states: sleep, deep-sleep, deep power-down
// - programmable divider scales the cpu clock from the main clock
// - one enable per peripheral; clearing it stops that clock entirely
// - some peripherals have their own programmable clock divider
// - sleep gates the core clock; wake only re-enables it
// - in sleep execution halts until reset or interrupt restarts the clock
// - peripheral clocks keep running in sleep
`default_nettype none

module scpc_top
    import scpc_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = PLL_LOCK_CYCLES
) (
    input  wire logic                              i_mclk,
    input  wire logic                              i_rstn,
    input  wire logic                              i_rc_osc,
    input  wire logic                              i_sys_osc,
    input  wire logic                              i_wdt_osc,
    input  wire logic                              i_ctl_osc,
    input  wire logic                              i_pll_ref_sel,
    input  wire logic                              i_pll_en,
    input  wire scpc_pll_cfg_t                     i_pll_cfg,
    input  wire logic [1:0]                        i_main_sel,
    input  wire logic                              i_main_sel_upd,
    input  wire logic [N_DIV-1:0][DIV_W-1:0]       i_div,
    input  wire logic [1:0]                        i_clock_output_pin_sel,
    input  wire logic [N_PERIPH-1:0]               i_periph_en,
    input  wire scpc_wdosc_cfg_t                   i_wdosc_cfg,
    input  wire logic                              i_pwr_enter,
    input  wire scpc_pwr_t                         i_pwr_mode,
    input  wire logic                              i_irq,
    input  wire logic                              i_wakeup_pin,
    output var  scpc_pll_stat_t                    o_pll_stat,
    output var  scpc_pll_cfg_t                     o_pll_cfg,
    output logic                                   o_main_clk,
    output logic [1:0]                             o_main_src,
    output logic                                   o_cpu_clk,
    output logic [N_PDIV-1:0]                      o_periph_div_clk,
    output var  logic [N_PERIPH-1:0]               o_periph_clk,
    output var  logic                              o_clock_output_pin,
    output var  logic                              o_wdt_clk,
    output var  scpc_wdosc_cfg_t                   o_wdosc_cfg,
    output scpc_pwr_t                              o_pwr_state
);

    localparam int unsigned LW = $clog2(LOCK_CYCLES + 1);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [3:0]        osc_s1;
    logic [3:0]        osc_s2;
    logic [3:0]        osc_q;
    logic              wake_s1;
    logic              wake_s2;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            osc_s1  <= 4'h0;
            osc_s2  <= 4'h0;
            osc_q   <= 4'h0;
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end else begin
            osc_s1  <= {i_ctl_osc, i_wdt_osc, i_sys_osc, i_rc_osc};
            osc_s2  <= osc_s1;
            osc_q   <= osc_s2;
            wake_s1 <= i_wakeup_pin;
            wake_s2 <= wake_s1;
        end
    end

    // ------------------------------------------------------------
    // power mode
    // ------------------------------------------------------------
    scpc_pwr_t         pwr;
    logic              dpd_exit;

    assign dpd_exit    = (pwr == PWR_DPD) && wake_s2;
    assign o_pwr_state = pwr;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            pwr <= PWR_RUN;
        end else begin
            case (pwr)
                PWR_RUN:    if (i_pwr_enter) pwr <= i_pwr_mode;
                PWR_SLEEP:  if (i_irq) pwr <= PWR_RUN;
                PWR_DSLEEP: if (i_irq || wake_s2) pwr <= PWR_RUN;
                PWR_DPD:    if (wake_s2) pwr <= PWR_RUN;
                default:    pwr <= PWR_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // system pll control
    // ------------------------------------------------------------
    logic              pll_on;
    logic              pll_locked;
    logic [LW-1:0]     lock_cnt;
    logic [3:0]        post_cnt;
    logic              ref_level;
    logic              pll_level;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            pll_on <= 1'b0;
        end else begin
            pll_on <= i_pll_en && (pwr != PWR_DPD);
        end
    end

    // five-bit field gives multiplier msel plus one
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pll_cfg <= RST_PLL_CFG;
        end else if (!pll_on) begin
            o_pll_cfg <= i_pll_cfg;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            lock_cnt   <= '0;
            pll_locked <= 1'b0;
        end else if (!pll_on) begin
            lock_cnt   <= '0;
            pll_locked <= 1'b0;
        end else if (lock_cnt == LW'(LOCK_CYCLES - 1)) begin
            pll_locked <= 1'b1;
        end else begin
            lock_cnt <= lock_cnt + LW'(1);
        end
    end

    // synchronous count of control oscillator rising edges, each bit a square wave
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            post_cnt <= 4'h0;
        end else if (!pll_on) begin
            post_cnt <= 4'h0;
        end else if (osc_s2[OSC_CTL] && !osc_q[OSC_CTL]) begin
            post_cnt <= post_cnt + 4'h1;
        end
    end

    assign ref_level = (i_pll_ref_sel == REF_RC) ? osc_s2[OSC_RC] : osc_s2[OSC_SYS];
    // bypass passes the reference straight through
    assign pll_level = pll_on ? post_cnt[o_pll_cfg.psel] : ref_level;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pll_stat <= '{powered_down: 1'b1, bypass: 1'b1, locked: 1'b0};
        end else begin
            o_pll_stat <= '{powered_down: !pll_on, bypass: !pll_on, locked: pll_locked};
        end
    end

    // ------------------------------------------------------------
    // main clock switch
    // ------------------------------------------------------------
    logic [3:0]        src;
    logic [1:0]        req_sel;
    logic [1:0]        act_sel;
    scpc_sw_t          sw;
    logic              main_clk;
    logic              main_q;
    logic              main_rise;
    logic              main_fall;

    assign src = {pll_level, osc_s2[OSC_WDT], osc_s2[OSC_SYS], osc_s2[OSC_RC]};

    // rc oscillator after reset and deep power-down wake
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            req_sel <= RST_MAIN_SEL;
        end else if (dpd_exit) begin
            req_sel <= SRC_RC;
        end else if (i_main_sel_upd) begin
            req_sel <= i_main_sel;
        end
    end

    // break on old low, make on new low
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sw       <= SW_RUN;
            act_sel  <= RST_MAIN_SEL;
            main_clk <= 1'b0;
        end else begin
            case (sw)
                SW_RUN: begin
                    main_clk <= src[act_sel];
                    // a switch to the pll only starts once it has locked
                    if (req_sel != act_sel && (req_sel != SRC_PLL || pll_locked)) begin
                        sw <= SW_DRAIN;
                    end
                end
                SW_DRAIN: begin
                    main_clk <= src[act_sel];
                    if (!src[act_sel]) sw <= SW_WAIT;
                end
                SW_WAIT: begin
                    main_clk <= 1'b0;
                    if (!src[req_sel]) begin
                        act_sel <= req_sel;
                        sw      <= SW_RUN;
                    end
                end
                default: begin
                    main_clk <= 1'b0;
                    sw       <= SW_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            main_q <= 1'b0;
        end else begin
            main_q <= main_clk;
        end
    end

    assign main_rise  = main_clk && !main_q;
    assign main_fall  = !main_clk && main_q;
    assign o_main_clk = main_clk;
    assign o_main_src = act_sel;

    // ------------------------------------------------------------
    // cpu and peripheral dividers (index 0 is the cpu)
    // ------------------------------------------------------------
    logic [N_DIV-1:0]  div_clk;
    logic [N_DIV-1:0]  div_gate;

    // cpu stops in any low-power mode, peripherals only in deep ones
    assign div_gate[0] = (pwr != PWR_RUN);
    for (genvar k = 1; k < N_DIV; k++) begin : g_pgate
        assign div_gate[k] = (pwr == PWR_DSLEEP) || (pwr == PWR_DPD);
    end

    for (genvar k = 0; k < N_DIV; k++) begin : g_div
        logic [DIV_W-1:0] cnt;
        logic [DIV_W-1:0] val;
        logic             clk;

        // ratio and gate sampled only at a period boundary
        always_ff @(posedge i_mclk or negedge i_rstn) begin
            if (!i_rstn) begin
                cnt <= '0;
                val <= RST_DIV;
                clk <= 1'b0;
            end else if (main_rise) begin
                if (val == '0 || cnt >= val - DIV_W'(1)) begin
                    cnt <= '0;
                    val <= i_div[k];
                    clk <= (i_div[k] != '0) && !div_gate[k];
                end else begin
                    cnt <= cnt + DIV_W'(1);
                    if (cnt + DIV_W'(1) == (val >> 1)) clk <= 1'b0;
                end
            end else if (main_fall && val == DIV_W'(1)) begin
                clk <= 1'b0;
            end
        end

        assign div_clk[k] = clk;
    end

    assign o_cpu_clk        = div_clk[0];
    assign o_periph_div_clk = div_clk[N_DIV-1:1];

    // ------------------------------------------------------------
    // peripheral clock gates
    // ------------------------------------------------------------
    logic [N_PERIPH-1:0] pen_q;

    // enables change only while main clock is low
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            pen_q <= '0;
        end else if (!main_clk) begin
            pen_q <= i_periph_en & {N_PERIPH{pwr == PWR_RUN || pwr == PWR_SLEEP}};
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_periph_clk <= '0;
        end else begin
            o_periph_clk <= {N_PERIPH{main_clk}} & pen_q;
        end
    end

    // ------------------------------------------------------------
    // clock output pin and watchdog oscillator
    // ------------------------------------------------------------
    // four-way output selector
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_clock_output_pin <= 1'b0;
        end else begin
            case (i_clock_output_pin_sel)
                CO_RC:     o_clock_output_pin <= osc_s2[OSC_RC];
                CO_SYSOSC: o_clock_output_pin <= osc_s2[OSC_SYS];
                CO_WDT:    o_clock_output_pin <= osc_s2[OSC_WDT];
                CO_MAIN:   o_clock_output_pin <= main_clk;
                default:   o_clock_output_pin <= 1'b0;
            endcase
        end
    end

    // watchdog timer clock and oscillator trim
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_wdt_clk   <= 1'b0;
            o_wdosc_cfg <= '0;
        end else begin
            o_wdt_clk   <= osc_s2[OSC_WDT];
            o_wdosc_cfg <= i_wdosc_cfg;
        end
    end

endmodule

`default_nettype wire

/* logic/scpc_pkg.sv */
// shared constants and types for the system clock and power control block
`default_nettype none

package scpc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ         = 200;
    localparam int unsigned PLL_SETTLE_US   = 100;
    localparam int unsigned PLL_LOCK_CYCLES = PLL_SETTLE_US * CLK_MHZ;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int unsigned N_PERIPH = 8;
    localparam int unsigned N_PDIV   = 3;
    localparam int unsigned N_DIV    = N_PDIV + 1;
    localparam int unsigned DIV_W    = 8;

    // ------------------------------------------------------------
    // source encodings and positions
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_RC     = 2'h0;
    localparam logic [1:0] SRC_SYSOSC = 2'h1;
    localparam logic [1:0] SRC_WDT    = 2'h2;
    localparam logic [1:0] SRC_PLL    = 2'h3;
    localparam logic [1:0] CO_RC      = 2'h0;
    localparam logic [1:0] CO_SYSOSC  = 2'h1;
    localparam logic [1:0] CO_WDT     = 2'h2;
    localparam logic [1:0] CO_MAIN    = 2'h3;
    localparam logic       REF_RC     = 1'h0;
    localparam int unsigned OSC_RC    = 0;
    localparam int unsigned OSC_SYS   = 1;
    localparam int unsigned OSC_WDT   = 2;
    localparam int unsigned OSC_CTL   = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0]       RST_MAIN_SEL = SRC_RC;
    localparam logic [DIV_W-1:0] RST_DIV      = 8'h01;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] msel;
        logic [1:0] psel;
    } scpc_pll_cfg_t;

    typedef struct packed {
        logic powered_down;
        logic bypass;
        logic locked;
    } scpc_pll_stat_t;

    typedef struct packed {
        logic [3:0] freqsel;
        logic [4:0] divsel;
    } scpc_wdosc_cfg_t;

    typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DSLEEP, PWR_DPD} scpc_pwr_t;
    typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_WAIT} scpc_sw_t;

    localparam scpc_pll_cfg_t RST_PLL_CFG = '{msel: 5'h00, psel: 2'h0};

endpackage

`default_nettype wire

/* tb/scpc_top_props.sv */
// assertion checker for the clock and power control block ports
`default_nettype none

module scpc_top_props
    import scpc_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = 20
) (
    input wire logic                i_mclk,
    input wire logic                i_rstn,
    input wire logic                i_pll_en,
    input wire logic                i_pwr_enter,
    input wire scpc_pwr_t           i_pwr_mode,
    input wire logic                i_irq,
    input wire scpc_pll_stat_t      o_pll_stat,
    input wire scpc_pll_cfg_t       o_pll_cfg,
    input wire logic                o_main_clk,
    input wire logic [1:0]          o_main_src,
    input wire logic                o_cpu_clk,
    input wire logic [N_PERIPH-1:0] o_periph_clk,
    input wire scpc_pwr_t           o_pwr_state
);
    localparam int LK1 = LOCK_CYCLES + 1;
    logic [6:0] st_cnt;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    // ------------------------------------------------------------
    // cycles spent in a reduced-power state
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_cnt <= 7'h00;
        end else if (o_pwr_state == PWR_RUN) begin
            st_cnt <= 7'h00;
        end else if (st_cnt != 7'h7F) begin
            st_cnt <= st_cnt + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_pll_off_bypass: assert property (
        !i_pll_en [*3] |-> o_pll_stat.powered_down && o_pll_stat.bypass)
        else $error("pll not bypassed while disabled");
    a_pll_on_time: assert property (
        $rose(i_pll_en) && o_pwr_state == PWR_RUN |-> o_pll_stat.powered_down
        ##2 !o_pll_stat.powered_down && !o_pll_stat.bypass)
        else $error("pll power-up timing wrong");
    a_lock_settle_time: assert property (
        $rose(i_pll_en) && o_pwr_state == PWR_RUN |->
        ##LK1 !o_pll_stat.locked ##1 o_pll_stat.locked)
        else $error("pll lock timing wrong");
    a_lock_drops: assert property (
        $fell(i_pll_en) |-> ##3 !o_pll_stat.locked)
        else $error("lock flag stayed after disable");
    a_cfg_frozen: assert property (
        !o_pll_stat.powered_down |-> $stable(o_pll_cfg))
        else $error("pll config changed while running");
    a_pll_src_locked: assert property (
        $changed(o_main_src) && o_main_src == SRC_PLL |-> o_pll_stat.locked)
        else $error("switched to pll before lock");
    a_main_no_runt: assert property (
        $rose(o_main_clk) |=> o_main_clk)
        else $error("runt pulse on main clock");
    a_cpu_no_runt: assert property (
        $fell(o_cpu_clk) |=> !o_cpu_clk)
        else $error("runt low pulse on cpu clock");
    a_pwr_enter_mode: assert property (
        o_pwr_state == PWR_RUN && i_pwr_enter |=> o_pwr_state == $past(i_pwr_mode))
        else $error("power mode not entered");
    a_irq_wakes: assert property (
        (o_pwr_state == PWR_SLEEP || o_pwr_state == PWR_DSLEEP) && i_irq
        |=> o_pwr_state == PWR_RUN)
        else $error("interrupt did not wake");
    a_sleep_cpu_stop: assert property (
        st_cnt >= 7'h40 |-> !o_cpu_clk)
        else $error("cpu clock runs in low power");
    a_deep_periph_stop: assert property (
        o_pwr_state inside {PWR_DSLEEP, PWR_DPD} && st_cnt >= 7'h40 |-> o_periph_clk == '0)
        else $error("peripheral clock runs in deep state");
    a_dpd_wake_rc: assert property (
        $past(o_pwr_state) == PWR_DPD && o_pwr_state == PWR_RUN
        |-> ##[0:200] o_main_src == SRC_RC)
        else $error("deep power-down wake not on rc");
endmodule

bind scpc_top scpc_top_props #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_pll_en(i_pll_en),
    .i_pwr_enter(i_pwr_enter), .i_pwr_mode(i_pwr_mode), .i_irq(i_irq),
    .o_pll_stat(o_pll_stat), .o_pll_cfg(o_pll_cfg), .o_main_clk(o_main_clk),
    .o_main_src(o_main_src), .o_cpu_clk(o_cpu_clk), .o_periph_clk(o_periph_clk),
    .o_pwr_state(o_pwr_state)
);

`default_nettype wire

/* tb/scpc_tb_top.sv */
// self-checking bench for the clock and power control block
`default_nettype none

module scpc_tb_top
    import scpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic                          i_mclk;
    logic                          i_rstn = 1'b0;
    logic                          i_rc_osc = 1'b0, i_sys_osc = 1'b0;
    logic                          i_wdt_osc = 1'b0, i_ctl_osc = 1'b0;
    logic                          i_pll_ref_sel = 1'b0, i_pll_en = 1'b0;
    scpc_pll_cfg_t                 i_pll_cfg = '{5'h00, 2'h0};
    logic [1:0]                    i_main_sel = 2'h0, i_clock_output_pin_sel = 2'h0;
    logic                          i_main_sel_upd = 1'b0;
    logic [N_DIV-1:0][DIV_W-1:0]   i_div = {4{8'h01}};
    logic [N_PERIPH-1:0]           i_periph_en = 8'hFF;
    scpc_wdosc_cfg_t               i_wdosc_cfg = 9'h1A5;
    logic                          i_pwr_enter = 1'b0, i_irq = 1'b0;
    scpc_pwr_t                     i_pwr_mode = PWR_RUN;
    logic                          i_wakeup_pin = 1'b0;
    scpc_pll_stat_t                o_pll_stat;
    scpc_pll_cfg_t                 o_pll_cfg;
    logic                          o_main_clk, o_cpu_clk, o_clock_output_pin, o_wdt_clk;
    logic [1:0]                    o_main_src;
    logic [N_PDIV-1:0]             o_periph_div_clk;
    logic [N_PERIPH-1:0]           o_periph_clk;
    scpc_wdosc_cfg_t               o_wdosc_cfg;
    scpc_pwr_t                     o_pwr_state;
    logic [7:0]                    osc_cnt = 8'h00;
    logic [6:0]                    mon, mon_q = 7'h00;
    int                            cnt [7], dlt [7], exp_co [4] = '{32, 16, 8, 32};
    int                            error_cnt, num_checks, n;

    scpc_top #(.LOCK_CYCLES(20)) uut (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_rc_osc(i_rc_osc), .i_sys_osc(i_sys_osc),
        .i_wdt_osc(i_wdt_osc), .i_ctl_osc(i_ctl_osc), .i_pll_ref_sel(i_pll_ref_sel),
        .i_pll_en(i_pll_en), .i_pll_cfg(i_pll_cfg), .i_main_sel(i_main_sel),
        .i_main_sel_upd(i_main_sel_upd), .i_div(i_div), .i_clock_output_pin_sel(i_clock_output_pin_sel),
        .i_periph_en(i_periph_en), .i_wdosc_cfg(i_wdosc_cfg), .i_pwr_enter(i_pwr_enter),
        .i_pwr_mode(i_pwr_mode), .i_irq(i_irq), .i_wakeup_pin(i_wakeup_pin),
        .o_pll_stat(o_pll_stat), .o_pll_cfg(o_pll_cfg), .o_main_clk(o_main_clk),
        .o_main_src(o_main_src), .o_cpu_clk(o_cpu_clk), .o_periph_div_clk(o_periph_div_clk),
        .o_periph_clk(o_periph_clk), .o_clock_output_pin(o_clock_output_pin),
        .o_wdt_clk(o_wdt_clk), .o_wdosc_cfg(o_wdosc_cfg), .o_pwr_state(o_pwr_state)
    );

    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    // oscillators with periods of 4, 8, 16 and 32 cycles, plus edge counters
    assign mon = {o_wdt_clk, o_periph_div_clk[0], o_periph_clk[1:0], o_cpu_clk, o_main_clk,
                  o_clock_output_pin};
    always @(posedge i_mclk) begin
        osc_cnt <= osc_cnt + 8'h01;
        i_ctl_osc <= osc_cnt[1];
        i_rc_osc <= osc_cnt[2];
        i_sys_osc <= osc_cnt[3];
        i_wdt_osc <= osc_cnt[4];
        mon_q <= mon;
        for (int k = 0; k < 7; k++) begin
            if (mon[k] && !mon_q[k]) begin
                cnt[k] <= cnt[k] + 1;
            end
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(input int c);
        repeat (c) @(posedge i_mclk);
    endtask

    task automatic measure(input int c);
        int s [7];
        s = cnt;
        tick(c);
        foreach (dlt[k]) dlt[k] = cnt[k] - s[k];
    endtask

    task automatic check_val(input string nm, input logic [8:0] exp, input logic [8:0] got);
        #1;
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic check_rng(input string nm, input int exp, input int got);
        num_checks++;
        if (got < exp - 1 || got > exp + 1) begin
            error_cnt++;
            $display("wrong value %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    task automatic sel_main(input logic [1:0] v);
        @(posedge i_mclk) i_main_sel <= v;
        i_main_sel_upd <= 1'b1;
        @(posedge i_mclk) i_main_sel_upd <= 1'b0;
    endtask

    task automatic wait_src(input logic [1:0] v);
        for (n = 0; n < 300 && o_main_src !== v; n++) @(posedge i_mclk);
        check_val("main source", 9'(v), 9'(o_main_src));
    endtask

    task automatic enter(input scpc_pwr_t m);
        @(posedge i_mclk) i_pwr_mode <= m;
        i_pwr_enter <= 1'b1;
        @(posedge i_mclk) i_pwr_enter <= 1'b0;
    endtask

    task automatic wake_pin();
        @(posedge i_mclk) i_wakeup_pin <= 1'b1;
        for (n = 0; n < 50 && o_pwr_state !== PWR_RUN; n++) @(posedge i_mclk);
        i_wakeup_pin <= 1'b0;
        check_val("power state", 9'(PWR_RUN), 9'(o_pwr_state));
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge i_mclk);
        error_cnt++;
        complete_run();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        tick(10);
        i_rstn <= 1'b1;
        tick(4);
        check_val("pll status", 9'h006, 9'(o_pll_stat));
        check_val("main source", 9'(SRC_RC), 9'(o_main_src));
        check_val("watchdog osc config", 9'h1A5, 9'(o_wdosc_cfg));
        for (int s = 0; s < 4; s++) begin
            @(posedge i_mclk) i_clock_output_pin_sel <= 2'(s);
            tick(8);
            measure(256);
            check_rng("clock output edges", exp_co[s], dlt[0]);
            check_rng("watchdog clock edges", 8, dlt[6]);
        end
        @(posedge i_mclk) i_div[0] <= 8'h04;
        i_div[1] <= 8'h02;
        i_periph_en <= 8'h01;
        tick(16);
        measure(256);
        check_rng("cpu edges", 8, dlt[2]);
        check_rng("divided peripheral edges", 16, dlt[5]);
        check_rng("enabled peripheral edges", 32, dlt[3]);
        check_val("disabled peripheral edges", 9'h000, 9'(dlt[4]));
        @(posedge i_mclk) i_div[0] <= 8'h00;
        tick(16);
        measure(128);
        check_val("stopped cpu edges", 9'h000, 9'(dlt[2]));
        @(posedge i_mclk) i_div[0] <= 8'h01;
        sel_main(SRC_WDT);
        wait_src(SRC_WDT);
        measure(256);
        check_rng("cpu edges on watchdog osc", 8, dlt[2]);
        sel_main(SRC_RC);
        wait_src(SRC_RC);
        @(posedge i_mclk) i_pll_cfg <= '{5'h04, 2'h1};
        i_pll_ref_sel <= 1'b1;
        @(posedge i_mclk) i_pll_en <= 1'b1;
        sel_main(SRC_PLL);
        tick(8);
        check_val("main source", 9'(SRC_RC), 9'(o_main_src));
        for (n = 0; n < 40 && o_pll_stat.locked !== 1'b1; n++) @(posedge i_mclk);
        check_val("pll status", 9'h001, 9'(o_pll_stat));
        wait_src(SRC_PLL);
        measure(256);
        check_rng("main edges on pll", 16, dlt[1]);
        @(posedge i_mclk) i_pll_cfg <= '{5'h1F, 2'h3};
        tick(4);
        check_val("pll config", 9'h011, 9'(o_pll_cfg));
        sel_main(SRC_RC);
        wait_src(SRC_RC);
        @(posedge i_mclk) i_pll_en <= 1'b0;
        tick(4);
        check_val("pll config", 9'h07F, 9'(o_pll_cfg));
        check_val("pll status", 9'h006, 9'(o_pll_stat));
        enter(PWR_SLEEP);
        tick(40);
        measure(128);
        check_val("cpu edges in sleep", 9'h000, 9'(dlt[2]));
        check_rng("peripheral edges in sleep", 16, dlt[3]);
        @(posedge i_mclk) i_irq <= 1'b1;
        @(posedge i_mclk) i_irq <= 1'b0;
        tick(2);
        check_val("power state", 9'(PWR_RUN), 9'(o_pwr_state));
        measure(128);
        check_rng("cpu edges after wake", 16, dlt[2]);
        enter(PWR_DSLEEP);
        tick(40);
        measure(128);
        check_val("peripheral edges in deep sleep", 9'h000, 9'(dlt[3]));
        wake_pin();
        sel_main(SRC_SYSOSC);
        wait_src(SRC_SYSOSC);
        enter(PWR_DPD);
        tick(40);
        check_val("power state", 9'(PWR_DPD), 9'(o_pwr_state));
        wake_pin();
        wait_src(SRC_RC);
        measure(256);
        check_rng("main edges after wake", 32, dlt[1]);
        complete_run();
    end
endmodule

`default_nettype wire
